// ==== fpr_defines.svh ====
`ifndef FPR_DEFINES_SVH
`define FPR_DEFINES_SVH

// ************************************************************
// register map
// ************************************************************
`define FPR_CFG_OFFSET 12'h000
`define FPR_STAT_OFFSET 12'h004
`define FPR_CFG_RESET 8'hFF
`define FPR_STAT_RESET 8'h00

// ************************************************************
// field positions
// ************************************************************
`define FPR_POPEN_BIT 7
`define FPR_NV6_BIT 6
`define FPR_HDIS_BIT 5
`define FPR_HS_HI 4
`define FPR_HS_LO 3
`define FPR_LDIS_BIT 2
`define FPR_LS_HI 1
`define FPR_LS_LO 0
`define FPR_VIOL_BIT 0
`define FPR_LOADED_BIT 1

// ************************************************************
// window bounds and protection byte location
// ************************************************************
`define FPR_HIGH_BASE0 16'hF800
`define FPR_HIGH_BASE1 16'hF000
`define FPR_HIGH_BASE2 16'hE000
`define FPR_HIGH_BASE3 16'hC000
`define FPR_LOW_BASE 16'h4000
`define FPR_LOW_END0 16'h41FF
`define FPR_LOW_END1 16'h43FF
`define FPR_LOW_END2 16'h47FF
`define FPR_LOW_END3 16'h4FFF
`define FPR_NV_ADDR 16'hFF0D

`endif

// ==== fpr_pkg.sv ====
`default_nettype none
`include "fpr_defines.svh"

package fpr_pkg;

    typedef enum logic [1:0] {
        FPR_LD_REQ = 2'b00,
        FPR_LD_TAKE = 2'b01,
        FPR_LD_RUN = 2'b10
    } fpr_load_state_t;

    typedef logic [2:0] fpr_scen_t;

    // scenario number is simply {polarity, high disable, low disable}
    function automatic fpr_scen_t fpr_scen(input logic [7:0] cfg);
        return {cfg[`FPR_POPEN_BIT], cfg[`FPR_HDIS_BIT], cfg[`FPR_LDIS_BIT]};
    endfunction : fpr_scen

    function automatic logic fpr_allowed(input fpr_scen_t from_s, input fpr_scen_t to_s);
        logic [7:0] row;
        case (from_s)
            3'h0: row = 8'h0F;
            3'h1: row = 8'h0A;
            3'h2: row = 8'h0C;
            3'h3: row = 8'h08;
            3'h4: row = 8'h18;
            3'h5: row = 8'h3C;
            3'h6: row = 8'h5A;
            default: row = 8'hFF;
        endcase
        return row[to_s];
    endfunction : fpr_allowed

    function automatic logic [15:0] fpr_high_base(input logic [1:0] sz);
        case (sz)
            2'b00: return `FPR_HIGH_BASE0;
            2'b01: return `FPR_HIGH_BASE1;
            2'b10: return `FPR_HIGH_BASE2;
            default: return `FPR_HIGH_BASE3;
        endcase
    endfunction : fpr_high_base

    function automatic logic [15:0] fpr_low_end(input logic [1:0] sz);
        case (sz)
            2'b00: return `FPR_LOW_END0;
            2'b01: return `FPR_LOW_END1;
            2'b10: return `FPR_LOW_END2;
            default: return `FPR_LOW_END3;
        endcase
    endfunction : fpr_low_end

endpackage : fpr_pkg

`default_nettype wire

// ==== fpr_chk_if.sv ====
`timescale 1ns/10ps
`default_nettype none

interface fpr_chk_if;
    logic [7:0] cfg;
    logic op_valid;
    logic [15:0] op_addr;
    logic op_mass;
    logic viol_pulse;
    logic op_done;

    modport verdict (
        input cfg,
        input op_valid,
        input op_addr,
        input op_mass,
        output viol_pulse,
        output op_done
    );

    modport owner (
        output cfg,
        output op_valid,
        output op_addr,
        output op_mass,
        input viol_pulse,
        input op_done
    );
endinterface : fpr_chk_if

`default_nettype wire

// ==== fpr_window_check.sv ====
`timescale 1ns/10ps
`default_nettype none

`include "fpr_defines.svh"

module fpr_window_check (
    input wire logic clk,
    input wire logic resetn,
    fpr_chk_if.verdict chk
);
    import fpr_pkg::*;

    logic viol_reg;
    logic done_reg;
    logic in_high;
    logic in_low;
    logic hit_protected;

    assign chk.viol_pulse = viol_reg;
    assign chk.op_done = done_reg;

    // ************************************************************
    // window decode
    // ************************************************************
    always_comb begin
        in_high = (chk.op_addr >= fpr_high_base(chk.cfg[`FPR_HS_HI:`FPR_HS_LO])) &&
                  !chk.cfg[`FPR_HDIS_BIT];
        in_low = (chk.op_addr >= `FPR_LOW_BASE) &&
                 (chk.op_addr <= fpr_low_end(chk.cfg[`FPR_LS_HI:`FPR_LS_LO])) &&
                 !chk.cfg[`FPR_LDIS_BIT];
        if (chk.cfg[`FPR_POPEN_BIT]) begin
            hit_protected = in_high || in_low;
        end else begin
            hit_protected = !(in_high || in_low);
        end
    end

    // ************************************************************
    // verdict, one cycle after the request
    // ************************************************************
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            viol_reg <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            done_reg <= chk.op_valid;
            if (chk.op_valid && chk.op_mass) begin
                // mass erase needs every window switched off in protect polarity
                viol_reg <= !(chk.cfg[`FPR_POPEN_BIT] && chk.cfg[`FPR_HDIS_BIT] &&
                              chk.cfg[`FPR_LDIS_BIT]);
            end else begin
                viol_reg <= chk.op_valid && hit_protected;
            end
        end
    end

    high_window_a: assert property (@(posedge clk) disable iff (!resetn)
        chk.op_valid && !chk.op_mass && chk.cfg[7] && !chk.cfg[5] &&
        chk.op_addr >= 16'hF800 |=> viol_reg)
        else $error("high window write not flagged");

    mass_erase_a: assert property (@(posedge clk) disable iff (!resetn)
        chk.op_valid && chk.op_mass |=> viol_reg == !(&{$past(chk.cfg[7]),
        $past(chk.cfg[5]), $past(chk.cfg[2])}))
        else $error("mass erase verdict wrong");

    full_array_a: assert property (@(posedge clk) disable iff (!resetn)
        chk.op_valid && !chk.op_mass && !chk.cfg[7] && chk.cfg[5] && chk.cfg[2]
        |=> viol_reg)
        else $error("full protection not enforced");

endmodule : fpr_window_check

`default_nettype wire

// ==== fpr_top.sv ====
// Decided for this implementation: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "fpr_defines.svh"

module fpr_top (
    input wire logic clk,
    input wire logic resetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    output logic nv_rd_req,
    output logic [15:0] nv_rd_addr,
    input wire logic [7:0] nv_prot_byte,
    input wire logic op_valid,
    input wire logic [15:0] op_addr,
    input wire logic op_mass,
    output logic op_violation,
    output logic op_done,
    output logic [7:0] prot_config,
    output logic violation_flag
);
    import fpr_pkg::*;

    fpr_load_state_t load_state_reg;
    logic nv_rd_req_reg;
    logic [15:0] nv_rd_addr_reg;
    logic [7:0] cfg_reg;
    logic [7:0] cfg_next;
    logic [7:0] cand;
    logic viol_reg;
    logic viol_next;
    logic wr_pend_reg;
    logic [11:0] wr_addr_reg;
    logic hreadyout_reg;
    logic [31:0] hrdata_reg;
    logic hresp_reg;
    logic addr_phase;
    logic cfg_wr;
    logic stat_wr;
    logic running;

    fpr_chk_if chk ();

    assign running = (load_state_reg == FPR_LD_RUN);
    assign hreadyout = hreadyout_reg;
    assign hrdata = hrdata_reg;
    assign hresp = hresp_reg;
    assign nv_rd_req = nv_rd_req_reg;
    assign nv_rd_addr = nv_rd_addr_reg;
    assign prot_config = cfg_reg;
    assign violation_flag = viol_reg;
    assign op_violation = chk.viol_pulse;
    assign op_done = chk.op_done;

    assign chk.cfg = cfg_reg;
    assign chk.op_valid = op_valid && running;
    assign chk.op_addr = op_addr;
    assign chk.op_mass = op_mass;

    // ************************************************************
    // reset-time load of the protection byte
    // ************************************************************
    // the array answers in the request cycle, taken on the next edge; until then no bus
    // write may touch the register, so the stored setting always wins
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            load_state_reg <= FPR_LD_REQ;
            nv_rd_req_reg <= 1'b0;
        end else begin
            case (load_state_reg)
                FPR_LD_REQ: begin
                    nv_rd_req_reg <= 1'b1;
                    load_state_reg <= FPR_LD_TAKE;
                end
                FPR_LD_TAKE: begin
                    nv_rd_req_reg <= 1'b0;
                    load_state_reg <= FPR_LD_RUN;
                end
                FPR_LD_RUN: begin
                    nv_rd_req_reg <= 1'b0;
                end
                default: begin
                    nv_rd_req_reg <= 1'b0;
                    load_state_reg <= FPR_LD_REQ;
                end
            endcase
        end
    end

    // address held in a register so every output leaves a flip-flop
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            nv_rd_addr_reg <= `FPR_NV_ADDR;
        end else begin
            nv_rd_addr_reg <= `FPR_NV_ADDR;
        end
    end

    // ************************************************************
    // ahb-lite slave
    // ************************************************************
    assign addr_phase = hsel && hready && htrans[1];

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 12'h000;
        end else begin
            wr_pend_reg <= addr_phase && hwrite;
            if (addr_phase) begin
                wr_addr_reg <= haddr[11:0];
            end
        end
    end

    always_comb begin
        cfg_wr = 1'b0;
        stat_wr = 1'b0;
        if (wr_pend_reg && wr_addr_reg == `FPR_CFG_OFFSET) begin
            cfg_wr = 1'b1;
        end else if (wr_pend_reg && wr_addr_reg == `FPR_STAT_OFFSET) begin
            stat_wr = 1'b1;
        end
    end

    // ************************************************************
    // protection register write filter
    // ************************************************************
    always_comb begin
        cand = hwdata[7:0];
        cand[`FPR_POPEN_BIT] = cfg_reg[`FPR_POPEN_BIT] & hwdata[`FPR_POPEN_BIT];
        if (!cfg_reg[`FPR_HDIS_BIT]) begin
            cand[`FPR_HS_HI:`FPR_HS_LO] = cfg_reg[`FPR_HS_HI:`FPR_HS_LO];
        end
        if (!cfg_reg[`FPR_LDIS_BIT]) begin
            cand[`FPR_LS_HI:`FPR_LS_LO] = cfg_reg[`FPR_LS_HI:`FPR_LS_LO];
        end
        cfg_next = cfg_reg;
        if (load_state_reg == FPR_LD_TAKE) begin
            cfg_next = nv_prot_byte;
        end else if (cfg_wr && running &&
                     fpr_allowed(fpr_scen(cfg_reg), fpr_scen(cand))) begin
            // scenario check covers both matrices; a failing write changes no bit
            cfg_next = cand;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cfg_reg <= `FPR_CFG_RESET;
        end else begin
            cfg_reg <= cfg_next;
        end
    end

    // ************************************************************
    // violation status, write one to clear
    // ************************************************************
    always_comb begin
        viol_next = viol_reg;
        if (stat_wr && hwdata[`FPR_VIOL_BIT]) begin
            viol_next = 1'b0;
        end
        // a new violation in the clearing cycle must not be lost
        if (chk.viol_pulse) begin
            viol_next = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            viol_reg <= 1'b0;
        end else begin
            viol_reg <= viol_next;
        end
    end

    // ************************************************************
    // read data and response
    // ************************************************************
    // read data built from next values so a read right after a write sees it
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            hrdata_reg <= 32'h00000000;
            hreadyout_reg <= 1'b1;
            hresp_reg <= 1'b0;
        end else begin
            hreadyout_reg <= 1'b1;
            hresp_reg <= 1'b0;
            if (addr_phase && !hwrite && haddr[11:0] == `FPR_CFG_OFFSET) begin
                hrdata_reg <= {24'h000000, cfg_next};
            end else if (addr_phase && !hwrite && haddr[11:0] == `FPR_STAT_OFFSET) begin
                hrdata_reg <= {30'h0, running, viol_next};
            end else begin
                hrdata_reg <= 32'h00000000;
            end
        end
    end

    fpr_window_check u_check (
        .clk(clk),
        .resetn(resetn),
        .chk(chk.verdict)
    );

    // ************************************************************
    // checks
    // ************************************************************
    sequence steady_s;
        running && $past(running);
    endsequence

    sequence cfg_read_s;
        addr_phase && !hwrite && haddr[11:0] == 12'h000;
    endsequence

    popen_no_rise_a: assert property (@(posedge clk) disable iff (!resetn)
        steady_s |-> !$rose(cfg_reg[7]))
        else $error("polarity bit went from 0 to 1");

    high_size_lock_a: assert property (@(posedge clk) disable iff (!resetn)
        steady_s and !$past(cfg_reg[5]) |-> cfg_reg[4:3] == $past(cfg_reg[4:3]))
        else $error("high size changed while window enabled");

    low_size_lock_a: assert property (@(posedge clk) disable iff (!resetn)
        steady_s and !$past(cfg_reg[2]) |-> cfg_reg[1:0] == $past(cfg_reg[1:0]))
        else $error("low size changed while window enabled");

    legal_move_a: assert property (@(posedge clk) disable iff (!resetn)
        steady_s |-> fpr_allowed(fpr_scen($past(cfg_reg)), fpr_scen(cfg_reg)))
        else $error("forbidden scenario transition taken");

    reset_load_a: assert property (@(posedge clk) disable iff (!resetn)
        nv_rd_req_reg |=> running && cfg_reg == $past(nv_prot_byte))
        else $error("protection byte not loaded");

    read_back_a: assert property (@(posedge clk) disable iff (!resetn)
        cfg_read_s |=> hrdata_reg[7:0] == cfg_reg && hrdata_reg[31:8] == 24'h000000)
        else $error("read data differs from active setting");

    viol_sticky_a: assert property (@(posedge clk) disable iff (!resetn)
        chk.viol_pulse |=> viol_reg ##1 (viol_reg || $past(stat_wr && hwdata[0])))
        else $error("violation flag not held");

    low_window_a: assert property (@(posedge clk) disable iff (!resetn)
        chk.op_valid && !op_mass && cfg_reg[7] && !cfg_reg[2] &&
        op_addr == 16'h41FF |=> chk.viol_pulse)
        else $error("low window write not flagged");

    no_protect_a: assert property (@(posedge clk) disable iff (!resetn)
        chk.op_valid && cfg_reg[7] && cfg_reg[5] && cfg_reg[2] |=> !chk.viol_pulse)
        else $error("violation with protection off");

    load_pulse_a: assert property (@(posedge clk) disable iff (!resetn)
        nv_rd_req_reg |=> !nv_rd_req_reg && nv_rd_addr_reg == 16'hFF0D)
        else $error("protection byte request not a single pulse");

    cfg_hold_a: assert property (@(posedge clk) disable iff (!resetn)
        steady_s and !$past(cfg_wr) |-> cfg_reg == $past(cfg_reg))
        else $error("setting changed without a write");

    high_size_write_a: assert property (@(posedge clk) disable iff (!resetn)
        cfg_wr && running && cfg_reg[5] && cfg_next != cfg_reg |=>
        cfg_reg[4:3] == $past(hwdata[4:3]))
        else $error("high size not written while window off");

    low_size_write_a: assert property (@(posedge clk) disable iff (!resetn)
        cfg_wr && running && cfg_reg[2] && cfg_next != cfg_reg |=>
        cfg_reg[1:0] == $past(hwdata[1:0]))
        else $error("low size not written while window off");

    viol_clear_a: assert property (@(posedge clk) disable iff (!resetn)
        stat_wr && hwdata[0] && !chk.viol_pulse |=> !viol_reg)
        else $error("violation flag not cleared");

    done_pulse_a: assert property (@(posedge clk) disable iff (!resetn)
        chk.op_valid |=> chk.op_done)
        else $error("operation verdict missing");

endmodule : fpr_top

`default_nettype wire

// ==== fpr_top_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "fpr_defines.svh"

module fpr_top_tb;
    // ************************************************************
    // stimulus and design
    // ************************************************************
    logic clk;
    logic resetn;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [31:0] hwdata;
    logic hreadyout;
    logic [31:0] hrdata;
    logic hresp;
    logic nv_rd_req;
    logic [15:0] nv_rd_addr;
    logic [7:0] nv_prot_byte;
    logic op_valid;
    logic [15:0] op_addr;
    logic op_mass;
    logic op_violation;
    logic op_done;
    logic [7:0] prot_config;
    logic violation_flag;
    int mismatches;
    int n_tests;
    logic [31:0] rdat;
    logic [7:0] oldc;
    logic [7:0] wc;
    logic [15:0] al [7];
    // allowed-destination masks, one row for each source scenario
    logic [7:0] rows [8] = '{8'h0F, 8'h0A, 8'h0C, 8'h08, 8'h18, 8'h3C, 8'h5A, 8'hFF};

    fpr_top dut (
        .clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .nv_rd_req(nv_rd_req),
        .nv_rd_addr(nv_rd_addr), .nv_prot_byte(nv_prot_byte), .op_valid(op_valid),
        .op_addr(op_addr), .op_mass(op_mass), .op_violation(op_violation),
        .op_done(op_done), .prot_config(prot_config), .violation_flag(violation_flag)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ************************************************************
    // reference model
    // ************************************************************
    function automatic logic [15:0] hbase(input logic [1:0] z);
        return (z == 2'h0) ? 16'hF800 : (z == 2'h1) ? 16'hF000 : (z == 2'h2) ? 16'hE000 : 16'hC000;
    endfunction : hbase

    function automatic logic [15:0] lend(input logic [1:0] z);
        return (z == 2'h0) ? 16'h41FF : (z == 2'h1) ? 16'h43FF : (z == 2'h2) ? 16'h47FF : 16'h4FFF;
    endfunction : lend

    function automatic logic prot(input logic [7:0] c, input logic [15:0] a);
        logic hit;
        hit = (!c[5] && a >= hbase(c[4:3])) || (!c[2] && a >= 16'h4000 && a <= lend(c[1:0]));
        return c[7] ? hit : !hit;
    endfunction : prot

    // polarity only falls, sizes follow the old disable bits, bad scenarios drop the write
    function automatic logic [7:0] next_cfg(input logic [7:0] o, input logic [7:0] w);
        logic [7:0] n;
        n = w;
        n[7] = o[7] & w[7];
        if (!o[5]) n[4:3] = o[4:3];
        if (!o[2]) n[1:0] = o[1:0];
        return rows[{o[7], o[5], o[2]}][{n[7], n[5], n[2]}] ? n : o;
    endfunction : next_cfg

    // ************************************************************
    // tasks
    // ************************************************************
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : stop_test

    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : check

    task automatic wait_rdy;
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (n >= 50) begin
            mismatches++;
            $display("CHECK FAILED hreadyout expected 1 seen %b", hreadyout);
            stop_test();
        end
    endtask : wait_rdy

    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy();
        rdat = hrdata;
        check("hresp", 32'h0, {31'h0, hresp});
    endtask : ahb

    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        ahb(1'b0, a, 32'h0);
        check("hrdata", e, rdat);
    endtask : rd

    // reset with a chosen protection byte in the array; load lands two edges after release
    task automatic load(input logic [7:0] b);
        nv_prot_byte <= b;
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        repeat (3) @(posedge clk);
    endtask : load

    task automatic op(input logic [15:0] a, input logic m, input logic e);
        @(posedge clk);
        op_valid <= 1'b1;
        op_addr <= a;
        op_mass <= m;
        @(posedge clk);
        op_valid <= 1'b0;
        op_mass <= 1'b0;
        #1;
        check("op_done", 32'h1, {31'h0, op_done});
        check("op_violation", {31'h0, e}, {31'h0, op_violation});
        @(posedge clk);
    endtask : op

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        resetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        nv_prot_byte = 8'hBF;
        op_valid = 1'b0;
        op_addr = 16'h0;
        op_mass = 1'b0;
        mismatches = 0;
        n_tests = 0;
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        #1;
        check("nv_rd_req", 32'h1, {31'h0, nv_rd_req});
        check("nv_rd_addr", 32'h0000FF0D, {16'h0, nv_rd_addr});
        @(posedge clk);
        #1;
        check("prot_config", 32'hBF, {24'h0, prot_config});
        check("nv_rd_req", 32'h0, {31'h0, nv_rd_req});
        @(posedge clk);
        rd(`FPR_CFG_OFFSET, 32'hBF);
        // unmapped offset reads zero and ignores writes
        ahb(1'b1, 32'h008, 32'hFF);
        rd(32'h008, 32'h0);
        check("prot_config", 32'hBF, {24'h0, prot_config});
        // every source scenario against every destination, sizes changed too
        for (int f = 0; f < 8; f++) begin
            for (int t = 0; t < 8; t++) begin
                oldc = {f[2], 1'b0, f[1], 2'h2, f[0], 2'h1};
                wc = {t[2], 1'b0, t[1], 2'h1, t[0], 2'h2};
                load(oldc);
                ahb(1'b1, `FPR_CFG_OFFSET, {24'h0, wc});
                rd(`FPR_CFG_OFFSET, {24'h0, next_cfg(oldc, wc)});
                check("prot_config", {24'h0, next_cfg(oldc, wc)}, {24'h0, prot_config});
            end
        end
        // window bounds for every scenario and size code, plus whole-array erase
        for (int s = 0; s < 8; s++) begin
            for (int z = 0; z < 4; z++) begin
                oldc = {s[2], 1'b0, s[1], z[1:0], s[0], z[1:0]};
                load(oldc);
                al = '{16'h3FFF, 16'h4000, lend(z[1:0]), lend(z[1:0]) + 16'h1,
                    hbase(z[1:0]) - 16'h1, hbase(z[1:0]), 16'hFFFF};
                for (int i = 0; i < 7; i++) begin
                    op(al[i], 1'b0, prot(oldc, al[i]));
                end
                op(16'h8000, 1'b1, !(oldc[7] && oldc[5] && oldc[2]));
            end
        end
        // sticky violation flag and its clear through the status word
        load(8'h00);
        op(16'h8000, 1'b0, 1'b1);
        @(posedge clk);
        #1;
        check("violation_flag", 32'h1, {31'h0, violation_flag});
        @(posedge clk);
        rd(`FPR_STAT_OFFSET, 32'h3);
        ahb(1'b1, `FPR_STAT_OFFSET, 32'h1);
        rd(`FPR_STAT_OFFSET, 32'h2);
        stop_test();
    end
endmodule : fpr_top_tb

`default_nettype wire
